// >>> pcd_pkg.sv
// constants, field layouts and state codes of the clock divider
// assumes one 100 mhz system clock; every user is written pcd_pkg::name
package pcd_pkg;

    // ------------------------------------------------------------------
    // widths and arithmetic
    // ------------------------------------------------------------------
    localparam int          MODE_W     = 9;
    localparam int          DIV_W      = 9;
    localparam int          CNT_W      = 10;
    localparam int          SHIFT_W    = MODE_W + DIV_W;
    localparam logic [9:0]  DIV_OFFSET = 10'h002;
    localparam logic [2:0]  PRE_STEP   = 3'h1;

    // ------------------------------------------------------------------
    // mode word layout, msb first
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] zero;
        logic       ref_out_off_bit;
        logic       pin_role_bit;
        logic       prescale_ratio;
        logic       prescale_bypass;
        logic       direct_route_bit;
        logic       ref_source;
    } pcd_mode_t;

    typedef struct packed {
        pcd_mode_t          mode_word;
        logic [DIV_W-1:0]   divider_word;
    } pcd_cfg_t;

    // factory image: sleep pin role, prescaler bypassed, divide by two
    localparam logic [MODE_W-1:0] FACTORY_MODE = 9'h014;
    localparam logic [DIV_W-1:0]  FACTORY_DIV  = 9'h000;

    // ------------------------------------------------------------------
    // pins, all asynchronous to clk_i
    // ------------------------------------------------------------------
    typedef struct packed {
        logic power_on;
        logic prog_mode;
        logic prog_clk;
        logic prog_write;
        logic data_in;
        logic ext_ref;
        logic sleep_sel;
        logic out_gate;
    } pcd_pins_t;

    // ------------------------------------------------------------------
    // power-down sequence
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_RUN      = 2'h0,
        PWR_MAIN_OFF = 2'h1,
        PWR_REF_OFF  = 2'h3,
        PWR_SLEEP    = 2'h2
    } pcd_pwr_t;

    // divisor is the programmed value plus two
    function automatic logic [CNT_W-1:0] divisor(
        input logic [DIV_W-1:0] n
    );
        divisor = {1'b0, n} + DIV_OFFSET;
    endfunction : divisor

endpackage : pcd_pkg

// >>> pcd_divider.sv
// programmable divider counter, counting rising edges of the master clock
// assumes tick_i and clear_i come from logic on clk_i
`timescale 1ns/1ps
module pcd_divider (
    // clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       reset_n_i,
    // control
    input  wire logic                       clear_i,
    input  wire logic                       tick_i,
    input  wire logic [pcd_pkg::DIV_W-1:0]  divisor_n_i,
    // divided level
    output logic                            div_o
);

    typedef struct packed {
        logic [pcd_pkg::CNT_W-1:0] cnt;
        logic                      out;
    } pcd_div_state_t;

    pcd_div_state_t            st;
    pcd_div_state_t            next_st;
    logic [pcd_pkg::CNT_W-1:0] last;
    logic [pcd_pkg::CNT_W-1:0] half;

    assign div_o = st.out;

    // ------------------------------------------------------------------
    // counter
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        last    = pcd_pkg::divisor(divisor_n_i) - 10'h001;
        half    = pcd_pkg::divisor(divisor_n_i) >> 1;
        if (clear_i) begin
            // parked on the last count so the first tick raises the output
            next_st.cnt = last;
            next_st.out = 1'b0;
        end else if (tick_i) begin
            next_st.cnt = (st.cnt >= last) ? '0 : st.cnt + 10'h001;
            next_st.out = next_st.cnt < half;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    div_clear_low_a: assert property (
        clear_i |=> !div_o && st.cnt == $past(last)
    ) else $error("divider not held while cleared");

    div_wrap_a: assert property (
        tick_i && !clear_i && st.cnt == last |=> st.cnt == '0 && div_o
    ) else $error("divider did not wrap after n plus two ticks");

endmodule : pcd_divider

// >>> pcd_clock_gen.sv
// clock generator: reference select, prescaler, divider, gating, sleep
// assumes all pins are asynchronous; clk_i stands for the on-chip oscillator
`timescale 1ns/1ps
module pcd_clock_gen (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    // supply and programming straps
    input  wire logic power_on_i,
    input  wire logic prog_mode_i,
    input  wire logic prog_clk_i,
    input  wire logic prog_write_i,
    // main clock pin
    input  wire logic main_clk_pin_i,
    output logic      main_clk_pin_o,
    output logic      main_clk_pin_oe_n_o,
    // reference pins
    input  wire logic ext_ref_pin_i,
    output logic      ref_clock_pin_o,
    output logic      ref_clock_pin_oe_n_o,
    // control pins
    input  wire logic sleep_select_pin_i,
    input  wire logic out_gate_i
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        pcd_pkg::pcd_pins_t             sync1;
        pcd_pkg::pcd_pins_t             sync2;
        pcd_pkg::pcd_pins_t             pins_d;
        logic                           powered;
        logic                           prog;
        pcd_pkg::pcd_cfg_t              nv;
        pcd_pkg::pcd_cfg_t              work;
        logic [pcd_pkg::SHIFT_W-1:0]    shreg;
        logic [2:0]                     pre_cnt;
        logic                           mclk_d;
        logic                           sel_ext;
        logic                           oe_s;
        logic                           gated;
        pcd_pkg::pcd_pwr_t              pwr;
        logic                           main_clk;
        logic                           main_oe_n;
        logic                           ref_clk;
        logic                           ref_oe_n;
    } pcd_state_t;

    pcd_state_t         st;
    pcd_state_t         next_st;
    pcd_pkg::pcd_pins_t pins_in;
    pcd_pkg::pcd_pins_t p;
    pcd_pkg::pcd_mode_t m;
    logic               pwr_rise;
    logic               clk_rise;
    logic               write_rise;
    logic               running;
    logic               osc_run;
    logic               int_lvl;
    logic               want_ext;
    logic               cand_lvl;
    logic               mclk;
    logic               mrise;
    logic               pd_req;
    logic               gate_req;
    logic               src;
    logic               div_out;
    logic               div_clear;

    assign pins_in = '{
        power_on:   power_on_i,
        prog_mode:  prog_mode_i,
        prog_clk:   prog_clk_i,
        prog_write: prog_write_i,
        data_in:    main_clk_pin_i,
        ext_ref:    ext_ref_pin_i,
        sleep_sel:  sleep_select_pin_i,
        out_gate:   out_gate_i
    };

    assign main_clk_pin_o       = st.main_clk;
    assign main_clk_pin_oe_n_o  = st.main_oe_n;
    assign ref_clock_pin_o      = st.ref_clk;
    assign ref_clock_pin_oe_n_o = st.ref_oe_n;

    // the divider counter is cleared from the registered gate, one cycle after it sets
    assign div_clear = st.gated | ~running;

    // ------------------------------------------------------------------
    // programmable divider
    // ------------------------------------------------------------------
    pcd_divider u_divider (
        .clk_i       (clk_i),
        .reset_n_i   (reset_n_i),
        .clear_i     (div_clear),
        .tick_i      (mrise),
        .divisor_n_i (st.work.divider_word),
        .div_o       (div_out)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st        = st;
        next_st.sync1  = pins_in;
        next_st.sync2  = st.sync1;
        next_st.pins_d = st.sync2;
        p          = st.sync2;
        m          = st.work.mode_word;
        pwr_rise   = p.power_on & ~st.pins_d.power_on;
        clk_rise   = p.prog_clk & ~st.pins_d.prog_clk;
        write_rise = p.prog_write & ~st.pins_d.prog_write;
        running    = st.powered & ~st.prog;
        osc_run    = running & (st.pwr != pcd_pkg::PWR_SLEEP);

        // prescaler; direct route on internal skips it as well
        if (m.prescale_bypass | m.direct_route_bit) begin
            int_lvl = st.pre_cnt[0];
        end else if (m.prescale_ratio) begin
            int_lvl = st.pre_cnt[1];
        end else begin
            int_lvl = st.pre_cnt[2];
        end

        // source bit unless the pin has the select role
        want_ext = m.pin_role_bit ? m.ref_source : ~p.sleep_sel;
        cand_lvl = want_ext ? p.ext_ref : int_lvl;
        if (!osc_run) begin
            mclk = 1'b0;
        end else if (st.sel_ext) begin
            mclk = p.ext_ref;
        end else begin
            mclk = int_lvl;
        end
        mrise = mclk & ~st.mclk_d;

        pd_req   = running & m.pin_role_bit & ~p.sleep_sel;
        gate_req = ~st.oe_s | pd_req | (st.pwr != pcd_pkg::PWR_RUN);
        src      = m.direct_route_bit ? mclk : div_out;

        if (!p.power_on) begin
            // supply off: working copy lost, both pins released
            next_st.powered   = 1'b0;
            next_st.prog      = 1'b0;
            next_st.pwr       = pcd_pkg::PWR_RUN;
            next_st.gated     = 1'b1;
            next_st.oe_s      = 1'b0;
            next_st.sel_ext   = 1'b0;
            next_st.mclk_d    = 1'b0;
            next_st.pre_cnt   = '0;
            next_st.work      = '0;
            next_st.main_clk  = 1'b0;
            next_st.main_oe_n = 1'b1;
            next_st.ref_clk   = 1'b0;
            next_st.ref_oe_n  = 1'b1;
        end else if (pwr_rise) begin
            next_st.powered = 1'b1;
            next_st.prog    = p.prog_mode;
            next_st.shreg   = '0;
            if (!p.prog_mode) begin
                next_st.work = st.nv;
            end
        end else if (st.prog) begin
            // main pin is the serial input, msb of the mode word first
            next_st.main_clk  = 1'b0;
            next_st.main_oe_n = 1'b1;
            next_st.ref_clk   = 1'b0;
            next_st.ref_oe_n  = 1'b1;
            if (clk_rise) begin
                next_st.shreg = {st.shreg[pcd_pkg::SHIFT_W-2:0], p.data_in};
            end
            if (write_rise) begin
                next_st.nv = st.shreg;
            end
        end else begin
            next_st.pre_cnt = osc_run ? st.pre_cnt + pcd_pkg::PRE_STEP
                                      : st.pre_cnt;
            next_st.mclk_d  = mclk;

            // switch only while both old and new references are low
            if (want_ext != st.sel_ext && !mclk && !cand_lvl) begin
                next_st.sel_ext = want_ext;
            end

            // gate input is only seen on master clock rises
            if (mrise) begin
                next_st.oe_s = p.out_gate;
            end

            // a high pulse in flight finishes before the gate closes
            next_st.gated    = gate_req & (st.gated | ~src);
            next_st.main_clk = ~next_st.gated & src;

            unique case (st.pwr)
                pcd_pkg::PWR_RUN: begin
                    if (pd_req) begin
                        next_st.pwr = pcd_pkg::PWR_MAIN_OFF;
                    end
                end
                pcd_pkg::PWR_MAIN_OFF: begin
                    if (!pd_req) begin
                        next_st.pwr = pcd_pkg::PWR_RUN;
                    end else if (st.gated && !mclk) begin
                        next_st.pwr = pcd_pkg::PWR_REF_OFF;
                    end
                end
                pcd_pkg::PWR_REF_OFF: begin
                    next_st.pwr = pcd_pkg::PWR_SLEEP;
                end
                pcd_pkg::PWR_SLEEP: begin
                    if (!pd_req) begin
                        next_st.pwr = pcd_pkg::PWR_RUN;
                    end
                end
            endcase

            next_st.main_oe_n = (st.pwr == pcd_pkg::PWR_SLEEP);
            // reference ignores the gate input and stops only when low
            next_st.ref_clk   = mclk & ~m.ref_out_off_bit &
                                (st.pwr != pcd_pkg::PWR_REF_OFF) &
                                (st.pwr != pcd_pkg::PWR_SLEEP);
            next_st.ref_oe_n  = m.ref_out_off_bit |
                                (st.pwr == pcd_pkg::PWR_SLEEP);
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // nv survives supply cycles; only the system reset restores factory
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st                        <= '0;
            st.nv.mode_word           <= pcd_pkg::FACTORY_MODE;
            st.nv.divider_word        <= pcd_pkg::FACTORY_DIV;
            st.gated                  <= 1'b1;
            st.pwr                    <= pcd_pkg::PWR_RUN;
            st.main_oe_n              <= 1'b1;
            st.ref_oe_n               <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    gate_holds_low_a: assert property (
        running && next_st.gated |=> !main_clk_pin_o
    ) else $error("main output high while gated");

    pulse_not_cut_a: assert property (
        running && p.power_on && !pwr_rise && gate_req && !st.gated && src
        |=> main_clk_pin_o
    ) else $error("main pulse truncated by gate");

    gate_clears_div_a: assert property (
        running && st.gated |=> !div_out
    ) else $error("divider not reset while gated");

    sleep_hiz_a: assert property (
        running && st.pwr == pcd_pkg::PWR_SLEEP && !pwr_rise && p.power_on
        |=> main_clk_pin_oe_n_o && ref_clock_pin_oe_n_o
    ) else $error("outputs driven in sleep");

    sleep_order_a: assert property (
        st.pwr == pcd_pkg::PWR_REF_OFF |-> st.gated && !st.main_clk
    ) else $error("reference stopped before main was gated");

    osc_stops_a: assert property (
        running && st.pwr == pcd_pkg::PWR_SLEEP && p.power_on
        |=> $stable(st.pre_cnt)
    ) else $error("oscillator runs in sleep");

    ref_off_bit_a: assert property (
        running && !pwr_rise && p.power_on && m.ref_out_off_bit
        |=> ref_clock_pin_oe_n_o && !ref_clock_pin_o
    ) else $error("reference driven with off bit set");

    ref_follows_a: assert property (
        running && !pwr_rise && p.power_on && !m.ref_out_off_bit &&
        st.pwr == pcd_pkg::PWR_RUN |=> ref_clock_pin_o == $past(mclk)
    ) else $error("reference output does not follow mux");

    direct_route_a: assert property (
        running && !pwr_rise && p.power_on && m.direct_route_bit &&
        !next_st.gated |=> main_clk_pin_o == $past(mclk)
    ) else $error("direct route not passed to main output");

    select_pin_a: assert property (
        running && p.power_on && !pwr_rise && !m.pin_role_bit && !mclk &&
        !cand_lvl |=> st.sel_ext == !$past(p.sleep_sel)
    ) else $error("select pin not steering reference");

    prog_input_a: assert property (
        st.prog && p.power_on && !pwr_rise |=> main_clk_pin_oe_n_o
    ) else $error("main pin driven in programming mode");

    load_at_powerup_a: assert property (
        $changed(st.work) |-> $past(!p.power_on || (pwr_rise && !p.prog_mode))
    ) else $error("working settings changed during operation");

    nv_write_a: assert property (
        st.prog && p.power_on && !pwr_rise && write_rise
        |=> st.nv == $past(st.shreg)
    ) else $error("write command did not store shifted words");

endmodule : pcd_clock_gen

// >>> pcd_clock_gen_test.sv
// testbench for the clock generator: programs, powers up and measures it
// assumes pcd_pkg and pcd_clock_gen are compiled before this file
`timescale 1ns/1ps
module pcd_clock_gen_test;

    // ------------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------------
    logic clk_i, reset_n_i, power_on_i, prog_mode_i, prog_clk_i;
    logic prog_write_i, main_clk_pin_i, ext_ref_pin_i;
    logic sleep_select_pin_i, out_gate_i;
    logic main_clk_pin_o, main_clk_pin_oe_n_o;
    logic ref_clock_pin_o, ref_clock_pin_oe_n_o;
    logic last_main, last_ref;
    int   num_errors = 0;
    int   checked = 0;
    int   cycles = 0;
    int   per, hi, n;
    int   lat [2];
    // external reference is slow enough for the two-flop synchroniser
    localparam int EXT_HALF = 10;
    localparam int CEILING  = 40000;
    logic [8:0] modes [8] = '{9'h00c, 9'h018, 9'h010, 9'h014,
                              9'h012, 9'h013, 9'h011, 9'h034};
    logic [8:0] divs [8]  = '{9'h003, 9'h000, 9'h001, 9'h1ff,
                              9'h1ff, 9'h000, 9'h000, 9'h000};
    bit         exts [8]  = '{0, 0, 0, 0, 0, 1, 1, 0};

    pcd_clock_gen dut (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .power_on_i(power_on_i),
        .prog_mode_i(prog_mode_i), .prog_clk_i(prog_clk_i),
        .prog_write_i(prog_write_i), .main_clk_pin_i(main_clk_pin_i),
        .main_clk_pin_o(main_clk_pin_o),
        .main_clk_pin_oe_n_o(main_clk_pin_oe_n_o),
        .ext_ref_pin_i(ext_ref_pin_i), .ref_clock_pin_o(ref_clock_pin_o),
        .ref_clock_pin_oe_n_o(ref_clock_pin_oe_n_o),
        .sleep_select_pin_i(sleep_select_pin_i), .out_gate_i(out_gate_i)
    );

    // ------------------------------------------------------------------
    // clocks and hang guard
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial begin
        ext_ref_pin_i = 1'b0;
        forever begin
            repeat (EXT_HALF) @(negedge clk_i);
            ext_ref_pin_i = ~ext_ref_pin_i;
        end
    end

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == CEILING) begin
            num_errors++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic results;
        $display("counts: %0d checked, %0d wrong", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check

    task automatic tick(input int k);
        repeat (k) @(negedge clk_i);
    endtask : tick

    // rise-to-rise period and high time, in clk cycles; ends on a rise
    task automatic measure(input bit use_ref);
        logic prev;
        logic cur;
        int   phase;
        prev = 1'b1;
        phase = 0;
        per = 0;
        hi = 0;
        for (int k = 0; k < 3000 && phase < 2; k++) begin
            @(negedge clk_i);
            cur = use_ref ? ref_clock_pin_o : main_clk_pin_o;
            if (cur === 1'b1 && prev === 1'b0) phase++;
            if (phase == 1) begin
                per++;
                hi += int'(cur === 1'b1);
            end
            prev = cur;
        end
    endtask : measure

    task automatic power(input logic prog);
        power_on_i = 1'b0;
        tick(8);
        prog_mode_i = prog;
        power_on_i = 1'b1;
        tick(12);
    endtask : power

    // shift an image msb first, write it, then power up operating
    task automatic load(input logic [8:0] m, input logic [8:0] d,
                        input logic prog);
        logic [17:0] img;
        img = {m, d};
        if (prog) power(1'b1);
        if (prog) check("prog oe_n", 2'b11, {main_clk_pin_oe_n_o,
                        ref_clock_pin_oe_n_o});
        for (int i = 17; i >= 0; i--) begin
            main_clk_pin_i = img[i];
            tick(4);
            prog_clk_i = 1'b1;
            tick(4);
            prog_clk_i = 1'b0;
            tick(4);
        end
        prog_write_i = 1'b1;
        tick(4);
        prog_write_i = 1'b0;
        tick(4);
        power(1'b0);
    endtask : load

    function automatic int mclk_per(input logic [8:0] m, input bit ext);
        if (ext) return 2 * EXT_HALF;
        if (m[1] || m[2]) return 2;
        return m[3] ? 4 : 8;
    endfunction : mclk_per

    task automatic run_cfg(input logic [8:0] m, input logic [8:0] d,
                           input bit ext);
        int mp;
        mp = mclk_per(m, ext);
        tick(60);
        check("main oe_n", 0, main_clk_pin_oe_n_o);
        measure(1'b0);
        check("main period", m[1] ? mp : mp * (d + 2), per);
        check("main high", m[1] ? mp / 2 : mp * ((d + 2) / 2), hi);
        if (m[5]) begin
            check("ref oe_n off", 1, ref_clock_pin_oe_n_o);
        end else begin
            measure(1'b1);
            check("ref period", mp, per);
        end
        $display("test config %h %h done", m, d);
    endtask : run_cfg

    // ------------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------------
    initial begin
        reset_n_i = 1'b0;
        power_on_i = 1'b0;
        prog_mode_i = 1'b0;
        prog_clk_i = 1'b0;
        prog_write_i = 1'b0;
        main_clk_pin_i = 1'b0;
        sleep_select_pin_i = 1'b1;
        out_gate_i = 1'b1;
        tick(16);
        check("reset oe_n", 2'b11, {main_clk_pin_oe_n_o,
              ref_clock_pin_oe_n_o});
        reset_n_i = 1'b1;
        tick(4);
        check("unpowered oe_n", 2'b11, {main_clk_pin_oe_n_o,
              ref_clock_pin_oe_n_o});
        power(1'b0);
        run_cfg(9'h014, 9'h000, 1'b0);
        for (int i = 0; i < 8; i++) begin
            load(modes[i], divs[i], 1'b1);
            run_cfg(modes[i], divs[i], exts[i]);
        end
        // shifting outside programming mode must change nothing
        load(9'h014, 9'h000, 1'b0);
        run_cfg(9'h034, 9'h000, 1'b0);
        // pin selects the reference, source bit ignored
        load(9'h005, 9'h000, 1'b1);
        run_cfg(9'h005, 9'h000, 1'b0);
        sleep_select_pin_i = 1'b0;
        run_cfg(9'h005, 9'h000, 1'b1);
        sleep_select_pin_i = 1'b1;
        run_cfg(9'h005, 9'h000, 1'b0);
        // output gate: no truncation, divider held, fixed release phase
        load(9'h014, 9'h002, 1'b1);
        run_cfg(9'h014, 9'h002, 1'b0);
        measure(1'b0);
        out_gate_i = 1'b0;
        n = 1;
        for (int k = 0; k < 20 && main_clk_pin_o === 1'b1; k++) begin
            tick(1);
            n += int'(main_clk_pin_o === 1'b1);
        end
        check("gated last pulse", 4, n);
        measure(1'b1);
        check("ref while gated", 2, per);
        for (int r = 0; r < 2; r++) begin
            // let a pulse in flight finish before counting
            tick(10);
            n = 0;
            for (int k = 0; k < 40; k++) begin
                tick(1);
                n += int'(main_clk_pin_o === 1'b1);
            end
            check("main while gated", 0, n);
            measure(1'b1);
            out_gate_i = 1'b1;
            lat[r] = 0;
            while (main_clk_pin_o !== 1'b1 && lat[r] < 40) begin
                tick(1);
                lat[r]++;
            end
            check("release window", 1, lat[r] >= 2 && lat[r] <= 12);
            measure(1'b0);
            check("period after release", 8, per);
            out_gate_i = 1'b0;
        end
        check("release phase", lat[0], lat[1]);
        out_gate_i = 1'b1;
        $display("test output gate done");
        // sleep: main low, then reference low, then both released
        tick(20);
        sleep_select_pin_i = 1'b0;
        last_main = 1'b1;
        last_ref = 1'b1;
        for (int k = 0; k < 60 && ref_clock_pin_oe_n_o !== 1'b1; k++) begin
            last_main = main_clk_pin_o;
            last_ref = ref_clock_pin_o;
            tick(1);
        end
        check("main before ref off", 0, last_main);
        check("ref before off", 0, last_ref);
        tick(30);
        check("sleep oe_n", 2'b11, {main_clk_pin_oe_n_o,
              ref_clock_pin_oe_n_o});
        sleep_select_pin_i = 1'b1;
        run_cfg(9'h014, 9'h002, 1'b0);
        // a second reset brings back the factory image
        reset_n_i = 1'b0;
        tick(3);
        reset_n_i = 1'b1;
        power(1'b0);
        run_cfg(9'h014, 9'h000, 1'b0);
        results();
    end

endmodule : pcd_clock_gen_test
